// ===== rtl/cmp_ctrl.v
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "cmp_map.vh"
module cmp_ctrl (
  input  wire                   REF_CLK,
  input  wire                   RESET,
  input  wire [`CMP_ADDR_W-1:0] ADDR,
  input  wire [7:0]             WR_DATA,
  input  wire                   WR_EN,
  input  wire                   RD_EN,
  output reg  [7:0]             RD_DATA,
  input  wire                   COMPARATOR_RESULT_ONE,
  input  wire                   COMPARATOR_RESULT_TWO,
  output reg  [3:0]             POS_NODE_SEL_ONE,
  output reg  [3:0]             POS_NODE_SEL_TWO,
  output reg  [3:0]             NEG_NODE_SEL_ONE,
  output reg  [3:0]             NEG_NODE_SEL_TWO,
  output reg  [1:0]             COMPARATOR_IRQ_FLAG,
  output reg                    IRQ
);

  // one-hot switch enables for the positive node
  function [3:0] pos_decode;
    input [1:0] sel;
    input       shared_ok;
    begin
      case (sel)
        `CMP_SEL_DEDICATED: pos_decode = 4'h1; // RL4
        `CMP_SEL_DAC:       pos_decode = 4'h2; // RL4
        `CMP_SEL_FIXED_REF: pos_decode = 4'h4; // RL4
        `CMP_SEL_SHARED:    pos_decode = shared_ok ? 4'h8 : 4'h0; // RL5 RL7
        default:            pos_decode = 4'h0;
      endcase
    end
  endfunction

  // one-hot switch enables for the negative node
  function [3:0] neg_decode;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    neg_decode = 4'h1; // RL6
        2'h1:    neg_decode = 4'h2; // RL6
        2'h2:    neg_decode = 4'h4; // RL6
        2'h3:    neg_decode = 4'h8; // RL6
        default: neg_decode = 4'h0;
      endcase
    end
  endfunction

  wire [8*`CMP_NUM-1:0] ctrl_all;
  wire [7:0]            ctrl_one;
  wire [7:0]            ctrl_two;
  reg  [`CMP_NUM-1:0]   status_r;
  reg  [`CMP_NUM-1:0]   status_nxt;
  reg  [`CMP_NUM-1:0]   mask_r;
  reg  [`CMP_NUM-1:0]   mask_nxt;
  reg  [7:0]            rd_nxt;
  reg  [3:0]            pos_one_nxt;
  reg  [3:0]            pos_two_nxt;
  reg  [3:0]            neg_one_nxt;
  reg  [3:0]            neg_two_nxt;
  reg  [`CMP_NUM-1:0]   flag_nxt;
  reg                   irq_nxt;
  wire [`CMP_NUM-1:0]   result;
  wire [`CMP_NUM-1:0]   edge_hit;
  wire [`CMP_NUM-1:0]   clr_bits;
  wire                  wr_status;
  wire                  wr_mask;

  assign result    = {COMPARATOR_RESULT_TWO, COMPARATOR_RESULT_ONE};
  assign wr_status = WR_EN & (ADDR == `CMP_ADDR_STATUS);
  assign wr_mask   = WR_EN & (ADDR == `CMP_ADDR_MASK);
  assign clr_bits  = wr_status ? WR_DATA[`CMP_NUM-1:0] : {`CMP_NUM{1'b0}};
  assign ctrl_one  = ctrl_all[7:0];
  assign ctrl_two  = ctrl_all[15:8];

  genvar g;
  generate
    for (g = 0; g < `CMP_NUM; g = g + 1) begin : g_cmp
      wire [`CMP_ADDR_W-1:0] my_addr;
      wire                   wr_mine;
      reg  [7:0]             ctrl_r;
      reg  [7:0]             ctrl_nxt;

      assign my_addr            = (g == 0) ? `CMP_ADDR_CTRL1 : `CMP_ADDR_CTRL2;
      assign wr_mine            = WR_EN & (ADDR == my_addr);
      assign ctrl_all[8*g +: 8] = ctrl_r;

      // control register, bits 3-2 stay zero
      always @* begin
        ctrl_nxt = ctrl_r;
        if (wr_mine) begin
          ctrl_nxt = WR_DATA & `CMP_CTRL_WMASK;
        end
      end

      always @(posedge REF_CLK) begin
        if (RESET) begin
          ctrl_r <= `CMP_CTRL_RESET;
        end else begin
          ctrl_r <= ctrl_nxt;
        end
      end

      cmp_edge u_edge (
        .clk        (REF_CLK),
        .rst        (RESET),
        .result     (result[g]),
        .rise_en    (ctrl_r[`CMP_BIT_RISE_EN]),
        .fall_en    (ctrl_r[`CMP_BIT_FALL_EN]),
        .edge_pulse (edge_hit[g])
      );
    end
  endgenerate

  // set wins over write-one-to-clear
  always @* begin
    status_nxt = (status_r & ~clr_bits) | edge_hit; // RL1 RL2
  end

  always @* begin
    mask_nxt = mask_r;
    if (wr_mask) begin
      mask_nxt = WR_DATA[`CMP_NUM-1:0];
    end
  end

  always @* begin
    rd_nxt = 8'h00;
    if (RD_EN) begin
      case (ADDR)
        `CMP_ADDR_CTRL1:  rd_nxt = ctrl_one;
        `CMP_ADDR_CTRL2:  rd_nxt = ctrl_two;
        `CMP_ADDR_MIRROR: rd_nxt = {6'h00, result}; // RL8
        `CMP_ADDR_STATUS: rd_nxt = {6'h00, status_r};
        `CMP_ADDR_MASK:   rd_nxt = {6'h00, mask_r};
        default:          rd_nxt = 8'h00;
      endcase
    end
  end

  // switch enables follow the control fields
  always @* begin
    pos_one_nxt = pos_decode(ctrl_one[`CMP_POS_HI:`CMP_POS_LO], 1'b1); // RL5
    pos_two_nxt = pos_decode(ctrl_two[`CMP_POS_HI:`CMP_POS_LO], 1'b0); // RL7
    neg_one_nxt = neg_decode(ctrl_one[`CMP_NEG_HI:`CMP_NEG_LO]); // RL6
    neg_two_nxt = neg_decode(ctrl_two[`CMP_NEG_HI:`CMP_NEG_LO]); // RL6
  end

  // flag copy and masked level
  always @* begin
    flag_nxt = status_r;
    irq_nxt  = |(status_r & mask_r);
  end

  always @(posedge REF_CLK) begin
    if (RESET) begin
      status_r <= {`CMP_NUM{1'b0}};
    end else begin
      status_r <= status_nxt;
    end
  end

  always @(posedge REF_CLK) begin
    if (RESET) begin
      mask_r <= {`CMP_NUM{1'b0}};
    end else begin
      mask_r <= mask_nxt;
    end
  end

  always @(posedge REF_CLK) begin
    if (RESET) begin
      RD_DATA <= 8'h00;
    end else begin
      RD_DATA <= rd_nxt;
    end
  end

  always @(posedge REF_CLK) begin
    if (RESET) begin
      POS_NODE_SEL_ONE <= 4'h0;
    end else begin
      POS_NODE_SEL_ONE <= pos_one_nxt;
    end
  end

  always @(posedge REF_CLK) begin
    if (RESET) begin
      POS_NODE_SEL_TWO <= 4'h0;
    end else begin
      POS_NODE_SEL_TWO <= pos_two_nxt;
    end
  end

  always @(posedge REF_CLK) begin
    if (RESET) begin
      NEG_NODE_SEL_ONE <= 4'h0;
    end else begin
      NEG_NODE_SEL_ONE <= neg_one_nxt;
    end
  end

  always @(posedge REF_CLK) begin
    if (RESET) begin
      NEG_NODE_SEL_TWO <= 4'h0;
    end else begin
      NEG_NODE_SEL_TWO <= neg_two_nxt;
    end
  end

  always @(posedge REF_CLK) begin
    if (RESET) begin
      COMPARATOR_IRQ_FLAG <= {`CMP_NUM{1'b0}};
    end else begin
      COMPARATOR_IRQ_FLAG <= flag_nxt;
    end
  end

  always @(posedge REF_CLK) begin
    if (RESET) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= irq_nxt;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/cmp_edge.v
`timescale 1ns/10ps
`default_nettype none
module cmp_edge (
  input  wire clk,
  input  wire rst,
  input  wire result,
  input  wire rise_en,
  input  wire fall_en,
  output reg  edge_pulse
);

  reg prev_r;
  reg primed_r;
  wire rise;
  wire fall;

  assign rise = primed_r & ~prev_r & result;
  assign fall = primed_r & prev_r & ~result;

  // first sample after reset only primes the history
  always @(posedge clk) begin
    if (rst) begin
      prev_r     <= 1'b0;
      primed_r   <= 1'b0;
      edge_pulse <= 1'b0;
    end else begin
      prev_r     <= result;
      primed_r   <= 1'b1;
      edge_pulse <= (rise & rise_en) | (fall & fall_en); // RL1 RL2 RL3
    end
  end

endmodule
`default_nettype wire

// ===== rtl/cmp_map.vh
// Notes on behaviour
// (RL1) rise edge enable set: a 0 to 1 result change sets the irq flag.
// (RL2) fall edge enable set: a 1 to 0 result change sets the irq flag.
// (RL3) fall enable clear ignores falls; both enables set catch both directions.
// (RL4) pos select 00 dedicated pin, 01 dac output, 10 fixed reference.
// (RL5) comparator one only: pos select 11 picks the shared positive pin.
// (RL6) neg select 00..11 picks shared negative pin 0..3.
// (RL7) comparator two: pos select 11 reserved, positive node left unconnected.
// (RL8) mirror register: bit1 result two, bit0 result one, rest zero.
`ifndef CMP_MAP_VH
`define CMP_MAP_VH

`define CMP_ADDR_W        3
`define CMP_ADDR_CTRL1    3'h0
`define CMP_ADDR_CTRL2    3'h1
`define CMP_ADDR_MIRROR   3'h2
`define CMP_ADDR_STATUS   3'h3
`define CMP_ADDR_MASK     3'h4

`define CMP_CTRL_RESET    8'h00
`define CMP_CTRL_WMASK    8'hF3
`define CMP_BIT_RISE_EN   7
`define CMP_BIT_FALL_EN   6
`define CMP_POS_HI        5
`define CMP_POS_LO        4
`define CMP_NEG_HI        1
`define CMP_NEG_LO        0

`define CMP_SEL_DEDICATED 2'h0
`define CMP_SEL_DAC       2'h1
`define CMP_SEL_FIXED_REF 2'h2
`define CMP_SEL_SHARED    2'h3

`define CMP_NUM           2

`endif

// ===== tb/cmp_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// comparator core: result follows commanded level one edge later
module cmp_core_model (
  input  wire logic       clk,
  input  wire logic [1:0] lvl,
  output var  logic [1:0] res
);
  always @(posedge clk) res <= lvl;
endmodule
`default_nettype wire

// ===== tb/cmp_ctrl_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module cmp_ctrl_chk (
  input wire logic       REF_CLK,
  input wire logic       RESET,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic       WR_EN,
  input wire logic       RD_EN,
  input wire logic [7:0] RD_DATA,
  input wire logic       COMPARATOR_RESULT_ONE,
  input wire logic       COMPARATOR_RESULT_TWO,
  input wire logic [3:0] POS_NODE_SEL_ONE,
  input wire logic [3:0] POS_NODE_SEL_TWO,
  input wire logic [3:0] NEG_NODE_SEL_ONE,
  input wire logic [1:0] COMPARATOR_IRQ_FLAG
);
  logic [7:0] c_r;
  logic [1:0] rs_r;
  wire        live;
  assign live = rs_r == 2'h0;
  // shadow of ctrl one, reset history
  always @(posedge REF_CLK) begin
    rs_r <= {rs_r[0], RESET};
    if (RESET)
      c_r <= 8'h00;
    else if (WR_EN && ADDR == 3'h0)
      c_r <= WR_DATA;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  property p_rise; live && $rose(COMPARATOR_RESULT_ONE) && c_r[7] |-> ##3 COMPARATOR_IRQ_FLAG[0]; endproperty
  a_rise: assert property (p_rise) else $error("rise edge lost");
  property p_fall; live && $fell(COMPARATOR_RESULT_ONE) && c_r[6] |-> ##3 COMPARATOR_IRQ_FLAG[0]; endproperty
  a_fall: assert property (p_fall) else $error("fall edge lost");
  property p_qual; $rose(COMPARATOR_IRQ_FLAG[0]) |-> $past(c_r[7] | c_r[6], 3); endproperty
  a_qual: assert property (p_qual) else $error("flag without enable");
  property p_pos1; WR_EN && ADDR == 3'h0 |-> ##2 POS_NODE_SEL_ONE == 4'h1 << $past(WR_DATA[5:4], 2);
  endproperty
  a_pos1: assert property (p_pos1) else $error("pos select one");
  property p_pos2; WR_EN && ADDR == 3'h1 && WR_DATA[5:4] != 2'h3
    |-> ##2 POS_NODE_SEL_TWO == 4'h1 << $past(WR_DATA[5:4], 2); endproperty
  a_pos2: assert property (p_pos2) else $error("pos select two");
  property p_resv; WR_EN && ADDR == 3'h1 && WR_DATA[5:4] == 2'h3 |-> ##2 POS_NODE_SEL_TWO == 4'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved select");
  property p_neg; WR_EN && ADDR == 3'h0 |-> ##2 NEG_NODE_SEL_ONE == 4'h1 << $past(WR_DATA[1:0], 2);
  endproperty
  a_neg: assert property (p_neg) else $error("neg select");
  property p_mir; RD_EN && ADDR == 3'h2 |=> RD_DATA ==
    {6'h00, $past(COMPARATOR_RESULT_TWO), $past(COMPARATOR_RESULT_ONE)}; endproperty
  a_mir: assert property (p_mir) else $error("mirror read");
endmodule
bind cmp_ctrl cmp_ctrl_chk chk_u (
  .REF_CLK               (REF_CLK),
  .RESET                 (RESET),
  .ADDR                  (ADDR),
  .WR_DATA               (WR_DATA),
  .WR_EN                 (WR_EN),
  .RD_EN                 (RD_EN),
  .RD_DATA               (RD_DATA),
  .COMPARATOR_RESULT_ONE (COMPARATOR_RESULT_ONE),
  .COMPARATOR_RESULT_TWO (COMPARATOR_RESULT_TWO),
  .POS_NODE_SEL_ONE      (POS_NODE_SEL_ONE),
  .POS_NODE_SEL_TWO      (POS_NODE_SEL_TWO),
  .NEG_NODE_SEL_ONE      (NEG_NODE_SEL_ONE),
  .COMPARATOR_IRQ_FLAG   (COMPARATOR_IRQ_FLAG)
);
`default_nettype wire

// ===== tb/tb_cmp_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module tb_cmp_ctrl;
  logic       clk = 0, rst = 1, we = 0, re = 0, irq;
  logic [2:0] a = 3'h0;
  logic [7:0] d = 8'h00, rdat;
  logic [1:0] lvl = 2'h0, res, flg;
  logic [3:0] p1, p2, n1, n2;
  int         error_cnt = 0, compares = 0;
  always #4 clk = ~clk;
  cmp_core_model mdl_u (.clk(clk), .lvl(lvl), .res(res));
  cmp_ctrl dut_u (.REF_CLK(clk), .RESET(rst), .ADDR(a), .WR_DATA(d), .WR_EN(we), .RD_EN(re),
    .RD_DATA(rdat), .COMPARATOR_RESULT_ONE(res[0]), .COMPARATOR_RESULT_TWO(res[1]),
    .POS_NODE_SEL_ONE(p1), .POS_NODE_SEL_TWO(p2), .NEG_NODE_SEL_ONE(n1),
    .NEG_NODE_SEL_TWO(n2), .COMPARATOR_IRQ_FLAG(flg), .IRQ(irq));
  task chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, s, e);
    end
  endtask
  task wr(input logic [2:0] ad, input logic [7:0] v);
    @(posedge clk);
    a <= ad;
    d <= v;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task rd(input logic [2:0] ad, input logic [7:0] e);
    @(posedge clk);
    a <= ad;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 chk(rdat, e);
  endtask
  task set_lvl(input logic [1:0] v);
    @(posedge clk) lvl <= v;
    repeat (5) @(posedge clk);
  endtask
  task report_and_stop;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #50000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    set_lvl(2'h2);
    rd(3'h2, 8'h02);
    @(posedge clk);
    #1 chk(rdat, 8'h00);
    wr(3'h4, 8'h01);
    wr(3'h0, 8'h80);
    set_lvl(2'h3);
    rd(3'h3, 8'h01);
    chk(irq, 1'b1);
    chk(flg, 8'h01);
    wr(3'h3, 8'h01);
    set_lvl(2'h2);
    rd(3'h3, 8'h00);
    chk(irq, 1'b0);
    wr(3'h0, 8'h40);
    set_lvl(2'h3);
    rd(3'h3, 8'h00);
    set_lvl(2'h2);
    rd(3'h3, 8'h01);
    wr(3'h4, 8'h00);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    wr(3'h3, 8'h01);
    wr(3'h4, 8'h02);
    wr(3'h1, 8'hC0);
    set_lvl(2'h0);
    rd(3'h3, 8'h02);
    chk(flg, 8'h02);
    chk(irq, 1'b1);
    wr(3'h3, 8'h02);
    rd(3'h3, 8'h00);
    set_lvl(2'h2);
    rd(3'h3, 8'h02);
    for (int k = 0; k < 4; k++) begin
      wr(3'h0, 8'(17 * k));
      wr(3'h1, 8'(17 * k));
      repeat (2) @(posedge clk);
      chk(p1, 8'(1 << k));
      chk(p2, k == 3 ? 8'h00 : 8'(1 << k));
      chk(n1, 8'(1 << k));
      chk(n2, 8'(1 << k));
    end
    rd(3'h0, 8'h33);
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'h00);
    wr(3'h1, 8'hFF);
    rd(3'h1, 8'hF3);
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(3'h1, 8'h00);
    chk(p2, 8'h01);
    chk(flg, 8'h00);
    report_and_stop;
  end
endmodule
`default_nettype wire
